//--- rtl/mpi_mgmt.sv
// Purpose: two-wire management serializer with divided management clock
// Assumes: requests only while not busy
// Notes: half period of the management clock is divider+1 system clocks
`timescale 1ns/1ps
module mpi_mgmt import mpi_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // sync reset, low
  input wire logic [7:0] mgmt_clock_divider, // half period minus one
  input wire logic start, // request pulse
  input wire mpi_mgmt_req_t req, // access fields
  output logic busy, // frame in progress
  output logic done, // frame finished pulse
  output logic [15:0] rdata, // read data
  output logic mgmt_clock_out, // management clock pin
  input wire logic mgmt_data_in, // data pin input
  output logic mgmt_data_out, // data pin output
  output logic mgmt_data_oe // data pin drive enable
);
  logic [7:0] div_q;
  logic mdc_q;
  logic busy_q;
  logic [5:0] bit_q;
  logic [63:0] sh_q;
  logic rd_q;
  logic [15:0] rdata_q;
  logic done_q;
  logic dout_q;
  logic oe_q;
  wire half_tick = busy_q && (div_q == mgmt_clock_divider);
  wire fall = half_tick && mdc_q;
  wire rise = half_tick && !mdc_q;
  wire in_rd_turn = rd_q && (bit_q >= MG_TA_BIT);
  wire [63:0] frame = {32'hffffffff, MG_ST, req.read ? MG_OP_RD : MG_OP_WR, req.phy_addr, req.reg_addr,
                       MG_TA_WR, req.wdata};

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      div_q <= 8'h00;
      mdc_q <= 1'b0;
      busy_q <= 1'b0;
      bit_q <= 6'h00;
      sh_q <= 64'h0;
      rd_q <= 1'b0;
      rdata_q <= 16'h0000;
      done_q <= 1'b0;
      dout_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      div_q <= half_tick || !busy_q ? 8'h00 : div_q + 8'h01;
      if (!busy_q && start) begin
        busy_q <= 1'b1;
        rd_q <= req.read;
        sh_q <= {frame[62:0], 1'b1};
        bit_q <= 6'h00;
        dout_q <= frame[63];
        oe_q <= 1'b1;
      end else if (rise) begin
        mdc_q <= 1'b1;
        if (in_rd_turn && bit_q > MG_TA_BIT + 6'h01) begin
          rdata_q <= {rdata_q[14:0], mgmt_data_in};
        end
      end else if (fall) begin
        mdc_q <= 1'b0;
        if (bit_q == MG_LAST_BIT) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          oe_q <= 1'b0;
        end else begin
          bit_q <= bit_q + 6'h01;
          dout_q <= sh_q[63];
          sh_q <= {sh_q[62:0], 1'b1};
          oe_q <= !(rd_q && (bit_q + 6'h01 >= MG_TA_BIT));
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign rdata = rdata_q;
  assign mgmt_clock_out = mdc_q;
  assign mgmt_data_out = dout_q;
  assign mgmt_data_oe = oe_q;
endmodule : mpi_mgmt

//--- rtl/mpi_mii.sv
// Purpose: MII pin interface: nibble transmit and receive, collision/carrier sync, management port
// Assumes: PHY clocks are sampled by sys_clk; nibble user streams are byte wide
// Notes: transmit and receive outputs change one sys_clk after the sampled rising edge of their PHY clock; tx_ready is high in the edge cycle itself
`timescale 1ns/1ps
module mpi_mii import mpi_pkg::*; (
  input wire logic sys_clk, // system clock, 40 MHz
  input wire logic rst_b, // sync reset, low
  input wire logic phy_tx_clock_in, // PHY transmit clock
  output logic [3:0] tx_nibble_out, // transmit nibble
  output logic tx_nibble_enable, // transmit enable
  input wire logic collision_in, // PHY collision
  input wire logic carrier_sense_in, // PHY carrier sense
  input wire logic phy_rx_clock_in, // PHY receive clock
  input wire logic [3:0] rx_nibble_in, // receive nibble
  input wire logic rx_nibble_valid, // receive data valid
  input wire logic rx_error_in, // receive error
  output logic mgmt_clock_out, // management clock
  input wire logic mgmt_data_in, // management data in
  output logic mgmt_data_out, // management data out
  output logic mgmt_data_oe, // management data drive enable
  input wire logic half_duplex, // half duplex mode
  input wire logic [15:0] max_frame_length, // longest valid frame, bytes
  input wire logic [7:0] mgmt_clock_divider, // management clock divider
  input wire logic tx_valid, // user byte available
  input wire logic [7:0] tx_byte, // user byte
  input wire logic tx_last, // byte ends the frame
  output logic tx_ready, // byte taken this cycle
  output logic tx_done, // frame ended pulse
  output logic tx_underflow, // underflow pulse
  output logic tx_collision, // collision abort pulse
  output logic col_sync, // synchronized collision
  output logic crs_sync, // synchronized carrier sense
  output logic rx_byte_valid, // received byte pulse
  output logic [7:0] rx_byte, // received byte
  output logic rx_frame_done, // frame end pulse
  output mpi_rx_status_t rx_status, // status of last frame
  input wire logic mgmt_start, // management request pulse
  input wire mpi_mgmt_req_t mgmt_req, // management request
  output logic mgmt_busy, // management busy
  output logic [15:0] mgmt_rdata, // management read data
  output logic mgmt_done // management done pulse
);
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_DATA, TX_FCS, TX_JAM, TX_GAP} mpi_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_DATA} mpi_rx_st_t;

  // pin sampling: two stages; the PHY clocks add an edge stage
  logic [2:0] txc_q;
  logic [2:0] rxc_q;
  logic [1:0] col_q;
  logic [1:0] crs_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      txc_q <= 3'h0;
      rxc_q <= 3'h0;
      col_q <= 2'h0;
      crs_q <= 2'h0;
    end else begin
      txc_q <= {txc_q[1:0], phy_tx_clock_in};
      rxc_q <= {rxc_q[1:0], phy_rx_clock_in};
      col_q <= {col_q[0], collision_in};
      crs_q <= {crs_q[0], carrier_sense_in};
    end
  end
  wire tx_edge = txc_q[1] && !txc_q[2];
  wire rx_edge = rxc_q[1] && !rxc_q[2];
  wire col_hd = half_duplex && col_q[1];
  wire defer = half_duplex && crs_q[1];

  // transmit
  mpi_tx_st_t tx_st_q;
  logic [4:0] tx_cnt_q;
  logic tx_hi_q;
  logic [7:0] tx_b_q;
  logic tx_last_q;
  logic [31:0] tx_crc_q;
  logic [31:0] fcs_q;
  logic [3:0] txd_q;
  logic txen_q;
  logic tx_done_q;
  logic tx_uf_q;
  logic tx_col_q;
  wire in_frame = (tx_st_q == TX_PRE) || (tx_st_q == TX_DATA) || (tx_st_q == TX_FCS);
  wire col_abort = tx_edge && in_frame && col_hd;
  wire take = tx_edge && (tx_st_q == TX_DATA) && !tx_hi_q && tx_valid && !col_abort;
  wire [31:0] crc_lo = mpi_crc_nib(tx_crc_q, tx_byte[3:0]);
  wire [31:0] crc_hi = mpi_crc_nib(tx_crc_q, tx_b_q[7:4]);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 5'h00;
      tx_hi_q <= 1'b0;
      tx_b_q <= 8'h00;
      tx_last_q <= 1'b0;
      tx_crc_q <= CRC_INIT;
      fcs_q <= 32'h0;
      txd_q <= 4'h0;
      txen_q <= 1'b0;
      tx_done_q <= 1'b0;
      tx_uf_q <= 1'b0;
      tx_col_q <= 1'b0;
    end else begin
      tx_done_q <= 1'b0;
      tx_uf_q <= 1'b0;
      tx_col_q <= 1'b0;
      if (col_abort) begin
        tx_st_q <= TX_JAM;
        tx_cnt_q <= 5'h01;
        txd_q <= JAM_NIB;
        tx_col_q <= 1'b1;
      end else if (tx_edge) begin
        case (tx_st_q)
          TX_IDLE: begin
            txen_q <= 1'b0;
            txd_q <= 4'h0;
            if (tx_valid && !defer) begin
              tx_st_q <= TX_PRE;
              tx_cnt_q <= 5'h01;
              tx_crc_q <= CRC_INIT;
              txd_q <= PRE_NIB;
              txen_q <= 1'b1;
            end
          end
          TX_PRE: begin
            txd_q <= (tx_cnt_q == PRE_LAST) ? SFD_NIB : PRE_NIB;
            tx_cnt_q <= tx_cnt_q + 5'h01;
            if (tx_cnt_q == PRE_LAST) begin
              tx_st_q <= TX_DATA;
              tx_hi_q <= 1'b0;
            end
          end
          TX_DATA: begin
            if (!tx_hi_q) begin
              if (tx_valid) begin
                tx_b_q <= tx_byte;
                tx_last_q <= tx_last;
                txd_q <= tx_byte[3:0];
                tx_crc_q <= crc_lo;
                tx_hi_q <= 1'b1;
              end else begin
                txd_q <= tx_crc_q[3:0];
                fcs_q <= tx_crc_q >> 4;
                tx_cnt_q <= 5'h01;
                tx_st_q <= TX_FCS;
                tx_uf_q <= 1'b1;
              end
            end else begin
              txd_q <= tx_b_q[7:4];
              tx_crc_q <= crc_hi;
              tx_hi_q <= 1'b0;
              if (tx_last_q) begin
                fcs_q <= ~crc_hi;
                tx_cnt_q <= 5'h00;
                tx_st_q <= TX_FCS;
              end
            end
          end
          TX_FCS: begin
            txd_q <= fcs_q[3:0];
            fcs_q <= fcs_q >> 4;
            tx_cnt_q <= tx_cnt_q + 5'h01;
            if (tx_cnt_q == FCS_LAST) begin
              tx_st_q <= TX_GAP;
              tx_cnt_q <= 5'h00;
              tx_done_q <= 1'b1;
            end
          end
          TX_JAM: begin
            txd_q <= JAM_NIB;
            tx_cnt_q <= tx_cnt_q + 5'h01;
            if (tx_cnt_q == JAM_LAST) begin
              tx_st_q <= TX_GAP;
              tx_cnt_q <= 5'h00;
              tx_done_q <= 1'b1;
            end
          end
          TX_GAP: begin
            txen_q <= 1'b0;
            txd_q <= 4'h0;
            tx_cnt_q <= tx_cnt_q + 5'h01;
            if (tx_cnt_q == GAP_LAST) begin
              tx_st_q <= TX_IDLE;
            end
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end

  // receive
  mpi_rx_st_t rx_st_q;
  logic rx_hi_q;
  logic [3:0] rx_lo_q;
  logic [7:0] rx_b_q;
  logic rx_v_q;
  logic rx_err_q;
  logic [15:0] rx_len_q;
  logic [31:0] rx_crc_q;
  logic rx_done_q;
  mpi_rx_status_t rx_stat_q;
  wire [31:0] rx_crc_n = mpi_crc_nib(mpi_crc_nib(rx_crc_q, rx_lo_q), rx_nibble_in);
  wire rx_err_n = rx_err_q || rx_error_in;
  wire len_ok = (rx_len_q >= 16'(MIN_FRAME_BYTES)) && (rx_len_q <= max_frame_length);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_st_q <= RX_IDLE;
      rx_hi_q <= 1'b0;
      rx_lo_q <= 4'h0;
      rx_b_q <= 8'h00;
      rx_v_q <= 1'b0;
      rx_err_q <= 1'b0;
      rx_len_q <= 16'h0000;
      rx_crc_q <= CRC_INIT;
      rx_done_q <= 1'b0;
      rx_stat_q <= '0;
    end else begin
      rx_v_q <= 1'b0;
      rx_done_q <= 1'b0;
      if (rx_edge) begin
        if (!rx_nibble_valid) begin
          if (rx_st_q == RX_DATA) begin
            rx_done_q <= 1'b1;
            rx_stat_q <= '{err: rx_err_q, crc_ok: rx_crc_q == CRC_RESIDUE, len_ok: len_ok, len: rx_len_q};
          end
          rx_st_q <= RX_IDLE;
        end else begin
          case (rx_st_q)
            RX_IDLE: begin
              rx_st_q <= RX_PRE;
              rx_err_q <= rx_error_in;
            end
            RX_PRE: begin
              rx_err_q <= rx_err_n;
              if (rx_nibble_in == SFD_NIB) begin
                rx_st_q <= RX_DATA;
                rx_hi_q <= 1'b0;
                rx_len_q <= 16'h0000;
                rx_crc_q <= CRC_INIT;
              end
            end
            RX_DATA: begin
              rx_err_q <= rx_err_n;
              if (!rx_hi_q) begin
                rx_lo_q <= rx_nibble_in;
                rx_hi_q <= 1'b1;
              end else begin
                rx_b_q <= {rx_nibble_in, rx_lo_q};
                rx_v_q <= 1'b1;
                rx_crc_q <= rx_crc_n;
                rx_len_q <= rx_len_q + 16'h0001;
                rx_hi_q <= 1'b0;
              end
            end
            default: rx_st_q <= RX_IDLE;
          endcase
        end
      end
    end
  end

  mpi_mgmt u_mgmt (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mgmt_clock_divider(mgmt_clock_divider),
    .start(mgmt_start),
    .req(mgmt_req),
    .busy(mgmt_busy),
    .done(mgmt_done),
    .rdata(mgmt_rdata),
    .mgmt_clock_out(mgmt_clock_out),
    .mgmt_data_in(mgmt_data_in),
    .mgmt_data_out(mgmt_data_out),
    .mgmt_data_oe(mgmt_data_oe)
  );

  assign tx_nibble_out = txd_q;
  assign tx_nibble_enable = txen_q;
  assign tx_ready = take;
  assign tx_done = tx_done_q;
  assign tx_underflow = tx_uf_q;
  assign tx_collision = tx_col_q;
  assign col_sync = col_q[1];
  assign crs_sync = crs_q[1];
  assign rx_byte_valid = rx_v_q;
  assign rx_byte = rx_b_q;
  assign rx_frame_done = rx_done_q;
  assign rx_status = rx_stat_q;
endmodule : mpi_mii

//--- rtl/mpi_pkg.sv
// Purpose: shared constants, types and helpers of the MII pin interface block
// Assumes: one system clock, PHY clocks sampled as ordinary inputs
// Notes: nibble bit 0 is the least significant bit on both data paths
package mpi_pkg;

  localparam int NIB_W = 4;
  localparam int SYS_CLK_HZ = 40000000;
  localparam int MIN_FRAME_BYTES = 64;
  localparam logic [15:0] MAX_FRAME_RST = 16'h05ee;
  localparam logic [3:0] PRE_NIB = 4'h5;
  localparam logic [3:0] SFD_NIB = 4'hd;
  localparam logic [3:0] JAM_NIB = 4'h5;
  localparam logic [4:0] PRE_LAST = 5'h0f;
  localparam logic [4:0] FCS_LAST = 5'h07;
  localparam logic [4:0] JAM_LAST = 5'h0b;
  localparam logic [4:0] GAP_LAST = 5'h17;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
  localparam logic [5:0] MG_PRE_BITS = 6'h20;
  localparam logic [5:0] MG_TA_BIT = 6'h2e;
  localparam logic [5:0] MG_LAST_BIT = 6'h3f;
  localparam logic [1:0] MG_ST = 2'b01;
  localparam logic [1:0] MG_OP_RD = 2'b10;
  localparam logic [1:0] MG_OP_WR = 2'b01;
  localparam logic [1:0] MG_TA_WR = 2'b10;

  typedef struct packed {
    logic read;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } mpi_mgmt_req_t;

  typedef struct packed {
    logic err;
    logic crc_ok;
    logic len_ok;
    logic [15:0] len;
  } mpi_rx_status_t;

  // reflected crc-32, one nibble, bit 0 first
  function automatic logic [31:0] mpi_crc_nib(input logic [31:0] crc, input logic [3:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 4; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : mpi_crc_nib

endpackage : mpi_pkg

//--- verification/mpi_mii_checker.sv
// Purpose: port-level checks of the MII pin interface
// Assumes: management divider is held at 3 while frames run
// Notes: bound into mpi_mii
`timescale 1ns/1ps
module mpi_mii_checker import mpi_pkg::*; (
  input wire logic sys_clk, // clock
  input wire logic rst_b, // reset, low
  input wire logic phy_tx_clock_in, // tx clock pin
  input wire logic [3:0] tx_nibble_out, // tx nibble
  input wire logic tx_nibble_enable, // tx enable
  input wire logic [7:0] tx_byte, // user byte
  input wire logic tx_ready, // byte taken
  input wire logic collision_in, // collision pin
  input wire logic carrier_sense_in, // carrier pin
  input wire logic col_sync, // synced collision
  input wire logic crs_sync, // synced carrier
  input wire logic mgmt_clock_out, // mgmt clock
  input wire logic [7:0] mgmt_clock_divider, // divider
  input wire logic mgmt_start, // mgmt request
  input wire logic mgmt_busy, // mgmt busy
  input wire logic mgmt_data_oe, // mgmt drive enable
  input wire logic mgmt_done, // mgmt done
  input wire logic rx_frame_done, // rx frame end
  input wire mpi_rx_status_t rx_status, // rx status
  input wire logic [15:0] max_frame_length // longest frame
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence mg_go;
    $rose(mgmt_busy) && mgmt_clock_divider == 8'h03 ##1 mgmt_busy [*4];
  endsequence
  tx_lsb_first_a: assert property (tx_ready |=> tx_nibble_enable && tx_nibble_out == $past(tx_byte[3:0]))
    else $error("low nibble not sent after byte taken");
  tx_en_sync_a: assert property ($changed(tx_nibble_enable) |-> phy_tx_clock_in)
    else $error("tx enable moved away from tx clock edge");
  tx_nib_sync_a: assert property ($changed(tx_nibble_out) |-> phy_tx_clock_in)
    else $error("tx nibble moved away from tx clock edge");
  tx_ready_en_a: assert property (tx_ready |-> tx_nibble_enable)
    else $error("byte taken while tx enable low");
  col_two_ff_a: assert property ($changed(col_sync) |-> col_sync == $past(collision_in, 2))
    else $error("collision sync not two stages");
  crs_two_ff_a: assert property ($changed(crs_sync) |-> crs_sync == $past(carrier_sense_in, 2))
    else $error("carrier sync not two stages");
  mg_start_a: assert property (mgmt_start && !mgmt_busy |=> mgmt_busy && mgmt_data_oe)
    else $error("mgmt frame did not start driving");
  mdc_half_a: assert property ($changed(mgmt_clock_out) && mgmt_clock_divider == 8'h03 |=> $stable(mgmt_clock_out) [*3])
    else $error("mgmt clock half period too short");
  mg_frame_a: assert property (mg_go |-> ##[470:540] mgmt_done)
    else $error("mgmt frame length wrong");
  rx_len_a: assert property (rx_frame_done |-> rx_status.len_ok == (rx_status.len >= 16'(MIN_FRAME_BYTES) && rx_status.len <= max_frame_length))
    else $error("rx length flag wrong");
endmodule : mpi_mii_checker

bind mpi_mii mpi_mii_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .phy_tx_clock_in(phy_tx_clock_in),
  .tx_nibble_out(tx_nibble_out), .tx_nibble_enable(tx_nibble_enable), .tx_byte(tx_byte), .tx_ready(tx_ready),
  .collision_in(collision_in), .carrier_sense_in(carrier_sense_in), .col_sync(col_sync), .crs_sync(crs_sync),
  .mgmt_clock_out(mgmt_clock_out), .mgmt_clock_divider(mgmt_clock_divider), .mgmt_start(mgmt_start),
  .mgmt_busy(mgmt_busy), .mgmt_data_oe(mgmt_data_oe), .mgmt_done(mgmt_done), .rx_frame_done(rx_frame_done),
  .rx_status(rx_status), .max_frame_length(max_frame_length));

//--- verification/mpi_phy_model.sv
// Purpose: behavioural PHY: free-running data clocks and management responder
// Assumes: management data line has a pull-up
// Notes: sh holds the last 64 management bits seen on clock rises
`timescale 1ns/1ps
module mpi_phy_model #(parameter logic [15:0] RD_VAL = 16'h3c5a) (
  output logic tx_clk, // transmit clock
  output logic rx_clk, // receive clock
  input wire logic mdc, // mgmt clock
  input wire logic md_out, // controller data
  input wire logic md_oe, // controller drive enable
  output wire logic md_in, // resolved data line
  output logic [63:0] sh // captured frame bits
);
  int cnt = 64;
  logic rd = 1'b0;
  wire logic drv = rd && cnt >= 47 && cnt <= 63 && !md_oe;
  initial begin
    tx_clk = 1'b0;
    sh = '0;
  end
  always #200 tx_clk = ~tx_clk;
  initial begin
    rx_clk = 1'b0;
    #137;
    forever #200 rx_clk = ~rx_clk;
  end
  // turnaround low then data msb first; released line floats high
  assign md_in = md_oe ? md_out : (drv ? (cnt == 47 ? 1'b0 : RD_VAL[63 - cnt]) : 1'b1);
  always @(posedge md_oe) begin
    cnt = 0;
    rd = 1'b0;
  end
  always @(posedge mdc) begin
    if (cnt == 34) rd <= md_in;
    sh <= {sh[62:0], md_in};
    if (cnt < 64) cnt <= cnt + 1;
  end
endmodule : mpi_phy_model

//--- verification/tb_mii_phy_pin_interface.sv
// Purpose: self-checking bench of the MII pin interface
// Assumes: PHY clocks at 2.5 MHz, management divider 3
// Notes: transmitted nibbles are looped back into the receive path
`timescale 1ns/1ps
module tb_mii_phy_pin_interface import mpi_pkg::*;;
  localparam logic [15:0] RD = 16'h3c5a;
  logic sys_clk = 1'b0, rst_b = 1'b0, collision_in = 1'b0, carrier_sense_in = 1'b0;
  logic rx_nibble_valid = 1'b0, rx_error_in = 1'b0, half_duplex = 1'b0;
  logic tx_valid = 1'b0, tx_last = 1'b0, mgmt_start = 1'b0;
  logic [3:0] rx_nibble_in = 4'h0;
  logic [7:0] tx_byte = 8'h00;
  logic [15:0] max_len = 16'h0040;
  mpi_mgmt_req_t mgmt_req = '0;
  wire tx_clk, rx_clk, mdc, md_out, md_oe, md_in, tx_en, tx_ready, tx_done, tx_underflow, tx_collision;
  wire rx_byte_valid, rx_frame_done, mgmt_done;
  wire [3:0] tx_nib;
  wire [7:0] rx_byte;
  wire [15:0] mgmt_rdata;
  wire [63:0] sh;
  wire mpi_rx_status_t rx_status;
  int err_count = 0, samples_checked = 0, done_seen = 0, uf_seen = 0, col_seen = 0;
  logic [3:0] capq[$];
  logic [7:0] rxq[$];

  mpi_mii u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .phy_tx_clock_in(tx_clk), .tx_nibble_out(tx_nib),
    .tx_nibble_enable(tx_en), .collision_in(collision_in), .carrier_sense_in(carrier_sense_in),
    .phy_rx_clock_in(rx_clk), .rx_nibble_in(rx_nibble_in), .rx_nibble_valid(rx_nibble_valid),
    .rx_error_in(rx_error_in), .mgmt_clock_out(mdc), .mgmt_data_in(md_in), .mgmt_data_out(md_out),
    .mgmt_data_oe(md_oe), .half_duplex(half_duplex), .max_frame_length(max_len), .mgmt_clock_divider(8'h03),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready), .tx_done(tx_done),
    .tx_underflow(tx_underflow), .tx_collision(tx_collision), .col_sync(), .crs_sync(),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_frame_done(rx_frame_done), .rx_status(rx_status),
    .mgmt_start(mgmt_start), .mgmt_req(mgmt_req), .mgmt_busy(), .mgmt_rdata(mgmt_rdata), .mgmt_done(mgmt_done));
  mpi_phy_model #(.RD_VAL(RD)) u_phy (.tx_clk(tx_clk), .rx_clk(rx_clk), .mdc(mdc), .md_out(md_out),
    .md_oe(md_oe), .md_in(md_in), .sh(sh));

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge tx_clk) if (tx_en === 1'b1) capq.push_back(tx_nib);
  always @(posedge sys_clk) begin
    if (tx_done === 1'b1) done_seen <= done_seen + 1;
    if (tx_underflow === 1'b1) uf_seen <= uf_seen + 1;
    if (tx_collision === 1'b1) col_seen <= col_seen + 1;
    if (rx_byte_valid === 1'b1) rxq.push_back(rx_byte);
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic send_tx(input int n, input int drop);
    int k, c0;
    k = 0;
    c0 = col_seen;
    capq.delete();
    @(negedge sys_clk);
    tx_valid = 1'b1;
    tx_byte = 8'h00;
    tx_last = (n == 1);
    while (k < n && k != drop && col_seen == c0) begin
      @(negedge sys_clk);
      if (tx_ready === 1'b1) begin
        @(negedge sys_clk);
        k++;
        tx_byte = 8'(k);
        tx_last = (k == n - 1);
      end
    end
    tx_valid = 1'b0;
    tx_last = 1'b0;
  endtask : send_tx

  task automatic wait_tx();
    int d0;
    d0 = done_seen;
    for (int i = 0; i < 6000 && done_seen == d0; i++) @(negedge sys_clk);
    chk("tx_done", 32'h1, 32'(done_seen - d0));
    repeat (28) @(posedge tx_clk);
  endtask : wait_tx

  task automatic send_rx(input int err_at, input logic [15:0] len, input logic lok, input logic cok, input logic er);
    rxq.delete();
    foreach (capq[i]) begin
      @(negedge rx_clk);
      @(negedge sys_clk);
      rx_nibble_valid = 1'b1;
      rx_nibble_in = capq[i];
      rx_error_in = (i == err_at);
    end
    @(negedge rx_clk);
    @(negedge sys_clk);
    rx_nibble_valid = 1'b0;
    rx_nibble_in = ~rx_nibble_in;
    rx_error_in = 1'b1;
    @(negedge rx_clk);
    @(negedge sys_clk);
    rx_error_in = 1'b0;
    chk("rx_len", 32'(len), 32'(rx_status.len));
    chk("rx_len_ok", 32'(lok), 32'(rx_status.len_ok));
    chk("rx_crc_ok", 32'(cok), 32'(rx_status.crc_ok));
    chk("rx_err", 32'(er), 32'(rx_status.err));
  endtask : send_rx

  task automatic test_tx_good();
    send_tx(60, -1);
    wait_tx();
    chk("tx_nibbles", 32'd144, 32'(capq.size()));
    for (int i = 0; i < 15; i++) chk("preamble", 32'h5, 32'(capq[i]));
    chk("sfd", 32'hd, 32'(capq[15]));
    for (int k = 0; k < 60; k++) begin
      chk("tx_lo", 32'(k % 16), 32'(capq[16 + 2 * k]));
      chk("tx_hi", 32'(k / 16), 32'(capq[17 + 2 * k]));
    end
    send_rx(-1, 16'd64, 1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 60; k++) chk("rx_byte", 32'(k), 32'(rxq[k]));
  endtask : test_tx_good

  task automatic test_rx_err();
    send_tx(61, -1);
    wait_tx();
    send_rx(40, 16'd65, 1'b0, 1'b1, 1'b1);
    max_len = 16'h0041;
    send_rx(-1, 16'd65, 1'b1, 1'b1, 1'b0);
  endtask : test_rx_err

  task automatic test_underflow();
    int u0;
    u0 = uf_seen;
    send_tx(30, 20);
    wait_tx();
    chk("tx_underflow", 32'h1, 32'(uf_seen - u0));
    chk("uf_nibbles", 32'd64, 32'(capq.size()));
    send_rx(-1, 16'd24, 1'b0, 1'b0, 1'b0);
  endtask : test_underflow

  task automatic test_collision();
    int c0;
    c0 = col_seen;
    half_duplex = 1'b1;
    fork
      send_tx(60, -1);
      begin
        repeat (1200) @(negedge sys_clk);
        collision_in = 1'b1;
        carrier_sense_in = 1'b1;
        repeat (60) @(negedge sys_clk);
        collision_in = 1'b0;
        carrier_sense_in = 1'b0;
      end
    join
    wait_tx();
    chk("tx_collision", 32'h1, 32'(col_seen - c0));
    for (int i = 1; i <= 12; i++) chk("jam", 32'h5, 32'(capq[capq.size() - i]));
    half_duplex = 1'b0;
  endtask : test_collision

  // busy medium holds a pending frame back until carrier drops
  task automatic test_defer();
    @(negedge sys_clk);
    half_duplex = 1'b1;
    carrier_sense_in = 1'b1;
    repeat (4) @(negedge sys_clk);
    tx_valid = 1'b1;
    repeat (64) @(negedge sys_clk);
    chk("defer_en", 32'h0, 32'(tx_en));
    carrier_sense_in = 1'b0;
    send_tx(1, -1);
    wait_tx();
    chk("defer_nibbles", 32'd26, 32'(capq.size()));
    half_duplex = 1'b0;
  endtask : test_defer

  task automatic mg_access(input logic rd);
    @(negedge sys_clk);
    mgmt_req = '{rd, 5'h09, 5'h12, 16'hb4e1};
    mgmt_start = 1'b1;
    @(negedge sys_clk);
    mgmt_start = 1'b0;
    for (int i = 0; i < 1000 && mgmt_done !== 1'b1; i++) @(negedge sys_clk);
    chk("mgmt_done", 32'h1, 32'(mgmt_done));
    if (rd) begin
      chk("mgmt_rdata", 32'(RD), 32'(mgmt_rdata));
    end else begin
      chk("mg_head", 32'hffffffff, sh[63:32]);
      chk("mg_body", {2'b01, 2'b01, 5'h09, 5'h12, 2'b10, 16'hb4e1}, sh[31:0]);
    end
  endtask : mg_access

  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    chk("reset_oe", 32'h0, 32'(md_oe));
    chk("reset_en", 32'h0, 32'(tx_en));
    test_tx_good();
    test_rx_err();
    test_underflow();
    test_collision();
    test_defer();
    mg_access(1'b0);
    mg_access(1'b1);
    print_verdict();
  end
  initial begin
    #1250000;
    err_count++;
    print_verdict();
  end
endmodule : tb_mii_phy_pin_interface
